//--- inc/asd_pkg.sv
/*
 * constants of the add/subtract datapath: register map, control fields,
 * flag positions, operation codes, reset values and state encoding.
 * assumes a 32-bit core datapath and word-indexed Avalon-MM addressing.
 */
// What this block does
// RULE1 - sum adds first operand to flexible operand or 12-bit immediate 0..4095
// RULE2 - sum-with-carry adds first operand, flexible operand and carry flag
// RULE3 - difference subtracts flexible operand or 12-bit immediate from first operand
// RULE4 - difference-with-borrow subtracts, then lowers result by one when carry clear
// RULE5 - reverse difference subtracts first operand from flexible operand
// RULE6 - with no destination named, result goes back to first operand register
// RULE7 - flags change only when flag update requested, else stay unchanged
// RULE8 - program counter as first operand has its two low bits cleared
// RULE9 - pc-plus-register writing pc branches to result with bit zero cleared
// RULE10 - software: pc first operand takes no flag update, constant 0..4095
// RULE11 - software: stack pointer target only plain sum/difference, shift at most 3
// RULE12 - wide-immediate sum and difference behave as 12-bit immediate forms
// RULE13 - software: pc destination takes no flag update, no pc/sp third operand
// RULE14 - 32-bit wraparound, carry is adder carry-out, overflow on signed overflow
package asd_pkg;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 4;

   // word indices on the register bus
   localparam logic [3:0] REG_OPA = 4'h0;
   localparam logic [3:0] REG_OPB = 4'h1;
   localparam logic [3:0] REG_CTRL = 4'h2;
   localparam logic [3:0] REG_CMD = 4'h3;
   localparam logic [3:0] REG_RESULT = 4'h4;
   localparam logic [3:0] REG_FLAGS = 4'h5;
   localparam logic [3:0] REG_STATUS = 4'h6;
   localparam logic [3:0] REG_DEST = 4'h7;
   localparam logic [3:0] REG_TARGET = 4'h8;
   localparam logic [3:0] REG_LAST = 4'h8;

   // control register fields
   localparam int unsigned CTL_OP_LSB = 0;
   localparam int unsigned CTL_SETF = 3;
   localparam int unsigned CTL_USE_IMM = 4;
   localparam int unsigned CTL_PC_SRC = 5;
   localparam int unsigned CTL_PC_DST = 6;
   localparam int unsigned CTL_SRC_LSB = 8;
   localparam int unsigned CTL_DST_LSB = 12;
   localparam int unsigned CTL_DST_GIVEN = 16;
   localparam int unsigned CTL_IMM_LSB = 20;

   localparam int unsigned CMD_START = 0;
   localparam int unsigned STS_BUSY = 0;
   localparam int unsigned STS_DONE = 1;

   // flag positions
   localparam int unsigned FLG_V = 0;
   localparam int unsigned FLG_C = 1;
   localparam int unsigned FLG_Z = 2;
   localparam int unsigned FLG_N = 3;

   // operation codes
   localparam logic [2:0] OP_SUM = 3'h0;
   localparam logic [2:0] OP_SUM_CARRY = 3'h1;
   localparam logic [2:0] OP_DIFFERENCE = 3'h2;
   localparam logic [2:0] OP_DIFFERENCE_WITH_BORROW = 3'h3;
   localparam logic [2:0] OP_REVERSE_DIFFERENCE = 3'h4;
   localparam logic [2:0] OP_WIDE_IMMEDIATE_SUM = 3'h5;
   localparam logic [2:0] OP_WIDE_IMMEDIATE_DIFFERENCE = 3'h6;

   // reset values
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [3:0] FLAGS_RST = 4'h0;

   typedef enum logic [1:0] {
      asd_st_idle = 2'b01,
      asd_st_calc = 2'b10
   } asd_state_t;

endpackage : asd_pkg

//--- logic/asd_adder.sv
/*
 * 32-bit adder with carry-in producing result and the four condition flags.
 * assumes subtraction is presented as a plus inverted operand plus carry-in.
 */
`timescale 1ns/1ps
module asd_adder #(
   parameter int unsigned W = 32
)(
   input wire logic [W-1:0] add_a,
   input wire logic [W-1:0] add_b,
   input wire logic add_cin,
   output logic [W-1:0] sum,
   output logic carry_out,
   output logic overflow,
   output logic negative,
   output logic zero
);

   logic [W:0] full_w;

   // carry-out doubles as not-borrow when add_b is inverted
   assign full_w = {1'b0, add_a} + {1'b0, add_b} + {{W{1'b0}}, add_cin}; // RULE14
   assign sum = full_w[W-1:0];
   assign carry_out = full_w[W];
   assign overflow = (add_a[W-1] == add_b[W-1]) & (sum[W-1] != add_a[W-1]); // RULE14
   assign negative = sum[W-1];
   assign zero = (sum == '0);

endmodule : asd_adder

//--- logic/asd_datapath.sv
/*
 * add/subtract datapath with an Avalon-MM register slave.
 * software loads operands and control, writes start, and reads result,
 * flags and destination; results are also pushed out to the register file.
 * assumes one clock, synchronous active-high reset, word-indexed addressing.
 */
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module asd_datapath (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic wb_valid,
   output logic [3:0] wb_index,
   output logic [31:0] wb_data,
   output logic branch_valid,
   output logic [31:0] branch_target,
   output logic [3:0] flags_out
);

   function automatic logic [31:0] be_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] be
   );
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            m[8*i +: 8] = new_v[8*i +: 8];
      end
      return m;
   endfunction : be_merge

   logic [31:0] opa_q;
   logic [31:0] opb_q;
   logic [31:0] ctrl_q;
   logic [31:0] result_q;
   logic [31:0] target_q;
   logic [31:0] readdata_q;
   logic [3:0] flags_q;
   logic [3:0] wb_index_q;
   logic done_q;
   logic done_d;
   logic wb_valid_q;
   logic branch_q;
   logic rd_pend_q;
   asd_pkg::asd_state_t st_q;
   asd_pkg::asd_state_t st_d;

   // control field decode
   logic [2:0] op_w;
   logic setf_w;
   logic use_imm_w;
   logic pc_src_w;
   logic pc_dst_w;
   logic dst_given_w;
   logic [3:0] src_idx_w;
   logic [3:0] dst_idx_w;
   logic [3:0] dest_w;
   logic [11:0] imm_w;
   logic carry_now;

   assign op_w = ctrl_q[asd_pkg::CTL_OP_LSB +: 3];
   assign setf_w = ctrl_q[asd_pkg::CTL_SETF];
   assign use_imm_w = ctrl_q[asd_pkg::CTL_USE_IMM];
   assign pc_src_w = ctrl_q[asd_pkg::CTL_PC_SRC];
   assign pc_dst_w = ctrl_q[asd_pkg::CTL_PC_DST];
   assign dst_given_w = ctrl_q[asd_pkg::CTL_DST_GIVEN];
   assign src_idx_w = ctrl_q[asd_pkg::CTL_SRC_LSB +: 4];
   assign dst_idx_w = ctrl_q[asd_pkg::CTL_DST_LSB +: 4];
   assign imm_w = ctrl_q[asd_pkg::CTL_IMM_LSB +: 12];
   assign carry_now = flags_q[asd_pkg::FLG_C];
   // no destination named: write back to the first operand register
   assign dest_w = dst_given_w ? dst_idx_w : src_idx_w; // RULE6

   // bus decode; registers are frozen while a calculation runs
   logic calc_w;
   logic wr_w;
   logic wr_opa_w;
   logic wr_opb_w;
   logic wr_ctrl_w;
   logic wr_flags_w;
   logic start_w;
   logic done_clr_w;

   assign calc_w = (st_q == asd_pkg::asd_st_calc);
   assign avs_waitrequest = calc_w | (avs_read & ~rd_pend_q);
   assign wr_w = avs_write & ~calc_w;
   assign wr_opa_w = wr_w & (avs_address == asd_pkg::REG_OPA);
   assign wr_opb_w = wr_w & (avs_address == asd_pkg::REG_OPB);
   assign wr_ctrl_w = wr_w & (avs_address == asd_pkg::REG_CTRL);
   assign wr_flags_w = wr_w & (avs_address == asd_pkg::REG_FLAGS) & avs_byteenable[0];
   assign start_w = wr_w & (avs_address == asd_pkg::REG_CMD) & avs_byteenable[0]
      & avs_writedata[asd_pkg::CMD_START];
   assign done_clr_w = wr_w & (avs_address == asd_pkg::REG_STATUS) & avs_byteenable[0]
      & avs_writedata[asd_pkg::STS_DONE];

   // datapath
   logic [31:0] a_eff_w;
   logic [31:0] b_sel_w;
   logic [31:0] add_a_w;
   logic [31:0] add_b_w;
   logic add_cin_w;
   logic [31:0] sum_w;
   logic cout_w;
   logic ovf_w;
   logic neg_w;
   logic zero_w;

   asd_operand_sel u_sel (
      .op(op_w),
      .use_imm(use_imm_w),
      .first_is_pc(pc_src_w),
      .first_val(opa_q),
      .flex_val(opb_q),
      .twelve_bit_immediate(imm_w),
      .carry_flag(carry_now),
      .a_eff(a_eff_w),
      .b_sel(b_sel_w),
      .add_a(add_a_w),
      .add_b(add_b_w),
      .add_cin(add_cin_w)
   );

   asd_adder #(
      .W(asd_pkg::DATA_W)
   ) u_add (
      .add_a(add_a_w),
      .add_b(add_b_w),
      .add_cin(add_cin_w),
      .sum(sum_w),
      .carry_out(cout_w),
      .overflow(ovf_w),
      .negative(neg_w),
      .zero(zero_w)
   );

   // sequencing
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         asd_pkg::asd_st_idle:
            if (start_w)
               st_d = asd_pkg::asd_st_calc;
         asd_pkg::asd_st_calc:
            st_d = asd_pkg::asd_st_idle;
         default:
            st_d = asd_pkg::asd_st_idle;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         st_q <= asd_pkg::asd_st_idle;
      else
         st_q <= st_d;
   end

   // operand and control registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         opa_q <= asd_pkg::WORD_RST;
         opb_q <= asd_pkg::WORD_RST;
         ctrl_q <= asd_pkg::WORD_RST;
      end
      else
      begin
         if (wr_opa_w)
            opa_q <= be_merge(opa_q, avs_writedata, avs_byteenable);
         if (wr_opb_w)
            opb_q <= be_merge(opb_q, avs_writedata, avs_byteenable);
         if (wr_ctrl_w)
            ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
      end
   end

   // results and pulses toward the register file
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         result_q <= asd_pkg::WORD_RST;
         target_q <= asd_pkg::WORD_RST;
         wb_index_q <= 4'h0;
         wb_valid_q <= 1'b0;
         branch_q <= 1'b0;
      end
      else
      begin
         wb_valid_q <= calc_w & ~pc_dst_w;
         branch_q <= calc_w & pc_dst_w; // RULE9
         if (calc_w)
         begin
            result_q <= sum_w; // RULE14
            wb_index_q <= dest_w; // RULE6
            target_q <= {sum_w[31:1], 1'b0}; // RULE9
         end
      end
   end

   // flags follow the result only on request; software may preload them
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         flags_q <= asd_pkg::FLAGS_RST;
      else if (calc_w && setf_w)
         flags_q <= {neg_w, zero_w, cout_w, ovf_w}; // RULE7 RULE14
      else if (wr_flags_w)
         flags_q <= avs_writedata[3:0];
   end

   // done is sticky; a new completion beats a clearing write
   assign done_d = calc_w | (done_q & ~done_clr_w);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         done_q <= 1'b0;
      else
         done_q <= done_d;
   end

   // readback
   logic [31:0] rd_words [0:8];
   logic [31:0] rd_mux_w;

   assign rd_words[0] = opa_q;
   assign rd_words[1] = opb_q;
   assign rd_words[2] = ctrl_q;
   assign rd_words[3] = 32'h0000_0000;
   assign rd_words[4] = result_q;
   assign rd_words[5] = {28'h0000000, flags_q};
   assign rd_words[6] = {30'h0, done_q, calc_w};
   assign rd_words[7] = {28'h0000000, wb_index_q};
   assign rd_words[8] = target_q;
   assign rd_mux_w = (avs_address <= asd_pkg::REG_LAST) ? rd_words[avs_address] : 32'h0000_0000;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rd_pend_q <= 1'b0;
         readdata_q <= asd_pkg::WORD_RST;
      end
      else
      begin
         rd_pend_q <= avs_read & ~rd_pend_q & ~calc_w;
         if (avs_read && !rd_pend_q && !calc_w)
            readdata_q <= rd_mux_w;
      end
   end

   assign avs_readdata = readdata_q;
   assign wb_valid = wb_valid_q;
   assign wb_index = wb_index_q;
   assign wb_data = result_q;
   assign branch_valid = branch_q;
   assign branch_target = target_q;
   assign flags_out = flags_q;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sum_result_a: assert property ( // RULE1
      (calc_w && op_w == asd_pkg::OP_SUM)
      |=> result_q == $past(a_eff_w) + $past(b_sel_w))
      else $error("sum result wrong");

   carry_sum_a: assert property ( // RULE2
      (calc_w && op_w == asd_pkg::OP_SUM_CARRY)
      |=> result_q == $past(a_eff_w) + $past(b_sel_w) + {31'h0, $past(carry_now)})
      else $error("sum with carry wrong");

   diff_result_a: assert property ( // RULE3
      (calc_w && op_w == asd_pkg::OP_DIFFERENCE)
      |=> result_q == $past(a_eff_w) - $past(b_sel_w))
      else $error("difference wrong");

   borrow_diff_a: assert property ( // RULE4
      (calc_w && op_w == asd_pkg::OP_DIFFERENCE_WITH_BORROW)
      |=> result_q == $past(a_eff_w) - $past(b_sel_w) - {31'h0, ~$past(carry_now)})
      else $error("difference with borrow wrong");

   reverse_diff_a: assert property ( // RULE5
      (calc_w && op_w == asd_pkg::OP_REVERSE_DIFFERENCE)
      |=> result_q == $past(b_sel_w) - $past(a_eff_w))
      else $error("reverse difference wrong");

   default_dest_a: assert property ( // RULE6
      (calc_w && !dst_given_w && !pc_dst_w)
      |=> wb_valid && wb_index == $past(src_idx_w) && wb_data == result_q)
      else $error("default destination wrong");

   flags_hold_a: assert property ( // RULE7
      (calc_w && !setf_w) |=> $stable(flags_q))
      else $error("flags changed without request");

   pc_align_a: assert property ( // RULE8
      (calc_w && pc_src_w && op_w == asd_pkg::OP_SUM && use_imm_w)
      |=> result_q[1:0] == $past(imm_w[1:0]))
      else $error("pc base not word aligned");

   branch_target_a: assert property ( // RULE9
      (calc_w && pc_dst_w)
      |=> branch_valid && !wb_valid && branch_target == {result_q[31:1], 1'b0} ##1 !branch_valid)
      else $error("branch target wrong");

   wide_sum_a: assert property ( // RULE12
      (calc_w && op_w == asd_pkg::OP_WIDE_IMMEDIATE_SUM)
      |=> result_q == $past(a_eff_w) + {20'h00000, $past(imm_w)})
      else $error("wide immediate sum wrong");

   carry_flag_a: assert property ( // RULE14
      (calc_w && setf_w)
      |=> flags_out[asd_pkg::FLG_C] == $past(cout_w) && flags_out[asd_pkg::FLG_Z] == (result_q == 32'h0))
      else $error("carry or zero flag wrong");

   busy_stall_a: assert property (
      (st_q == asd_pkg::asd_st_idle && start_w)
      |=> avs_waitrequest ##1 (st_q == asd_pkg::asd_st_idle && done_q))
      else $error("calculation timing wrong");

endmodule : asd_datapath

//--- logic/asd_operand_sel.sv
/*
 * operand steering for the add/subtract forms: immediate selection,
 * program counter alignment, operand swap and inversion, carry-in choice.
 * assumes op codes from asd_pkg; unknown codes behave as a plain sum.
 */
`timescale 1ns/1ps
module asd_operand_sel (
   input wire logic [2:0] op,
   input wire logic use_imm,
   input wire logic first_is_pc,
   input wire logic [31:0] first_val,
   input wire logic [31:0] flex_val,
   input wire logic [11:0] twelve_bit_immediate,
   input wire logic carry_flag,
   output logic [31:0] a_eff,
   output logic [31:0] b_sel,
   output logic [31:0] add_a,
   output logic [31:0] add_b,
   output logic add_cin
);

   logic wide_w;
   logic imm_ok_w;
   logic minus_w;
   logic rev_w;
   logic carry_op_w;

   assign wide_w = (op == asd_pkg::OP_WIDE_IMMEDIATE_SUM) | (op == asd_pkg::OP_WIDE_IMMEDIATE_DIFFERENCE); // RULE12
   assign imm_ok_w = wide_w | (use_imm & ((op == asd_pkg::OP_SUM) | (op == asd_pkg::OP_DIFFERENCE))); // RULE1 RULE3
   assign minus_w = (op == asd_pkg::OP_DIFFERENCE) | (op == asd_pkg::OP_DIFFERENCE_WITH_BORROW)
      | (op == asd_pkg::OP_WIDE_IMMEDIATE_DIFFERENCE);
   assign rev_w = (op == asd_pkg::OP_REVERSE_DIFFERENCE);
   assign carry_op_w = (op == asd_pkg::OP_SUM_CARRY) | (op == asd_pkg::OP_DIFFERENCE_WITH_BORROW);

   // word-aligned base when the program counter feeds the first operand
   assign a_eff = first_is_pc ? {first_val[31:2], 2'b00} : first_val; // RULE8
   assign b_sel = imm_ok_w ? {20'h00000, twelve_bit_immediate} : flex_val; // RULE1 RULE3 RULE12
   assign add_a = rev_w ? b_sel : a_eff; // RULE5
   assign add_b = rev_w ? ~a_eff : (minus_w ? ~b_sel : b_sel); // RULE3 RULE5
   // clear carry on borrow form leaves the extra minus one in place
   assign add_cin = carry_op_w ? carry_flag : (minus_w | rev_w); // RULE2 RULE4

endmodule : asd_operand_sel

//--- verif/add_subtract_datapath_tb.sv
/*
 * self-checking bench of the add/subtract datapath: bus tasks, reference
 * arithmetic, corner table, immediate and pc forms, random operations.
 * assumes the register map and control layout of the datapath package.
 */
`timescale 1ns/1ps
module add_subtract_datapath_tb;
   logic clk, sys_rst, avs_read, avs_write, wb_valid, branch_valid, avs_waitrequest;
   logic [3:0] avs_address, avs_byteenable, wb_index, flags_out;
   logic [31:0] avs_writedata, avs_readdata, wb_data, branch_target, rd, c, seed_v;
   logic [2:0] op;
   int miscompares, checks_done, k, j;
   logic [31:0] ca [4] = '{32'h7fffffff, 32'hffffffff, 32'h0, 32'h80000000};
   logic [31:0] cb [4] = '{32'h1, 32'h1, 32'h0, 32'hffffffff};

   asd_datapath asd_datapath_inst (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data), .branch_valid(branch_valid),
      .branch_target(branch_target), .flags_out(flags_out));
   asd_regfile_model asd_regfile_model_inst (.clk(clk), .sys_rst(sys_rst), .wb_valid(wb_valid),
      .wb_index(wb_index), .wb_data(wb_data), .branch_valid(branch_valid), .branch_target(branch_target));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic close_out();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // request held until waitrequest is seen low at a rising edge
   task automatic bus_wr(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      avs_address <= ad;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [3:0] ad, output logic [31:0] d);
      @(posedge clk);
      avs_address <= ad;
      avs_read <= 1'b1;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask : bus_rd

   function automatic logic [31:0] mk(input logic [2:0] o, input logic sf, input logic ie,
      input logic ps, input logic pd, input logic [3:0] src, input logic [3:0] dst,
      input logic gv, input logic [11:0] im);
      return {im, 3'h0, gv, dst, src, 1'b0, pd, ps, ie, sf, o};
   endfunction : mk

   // reference result: {flags N Z C V, result}
   function automatic logic [35:0] calc(input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] ct, input logic [3:0] fin);
      logic [31:0] x, y, bs, ae;
      logic ci;
      logic [32:0] s;
      logic [3:0] f;
      logic [2:0] o;
      o = ct[2:0];
      ae = ct[5] ? {a[31:2], 2'h0} : a;
      bs = (o == 3'h5 || o == 3'h6 || (ct[4] && (o == 3'h0 || o == 3'h2))) ? {20'h0, ct[31:20]} : b;
      x = ae;
      y = bs;
      ci = 1'b0;
      case (o)
         3'h1: ci = fin[1];
         3'h2, 3'h6:
         begin
            y = ~bs;
            ci = 1'b1;
         end
         3'h3:
         begin
            y = ~bs;
            ci = fin[1];
         end
         3'h4:
         begin
            x = bs;
            y = ~ae;
            ci = 1'b1;
         end
         default: ;
      endcase
      s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
      f = {s[31], s[31:0] == 32'h0, s[32], (x[31] == y[31]) && (s[31] != x[31])};
      return {ct[3] ? f : fin, s[31:0]};
   endfunction : calc

   task automatic run_op(input logic [31:0] a, input logic [31:0] b, input logic [31:0] ct,
      input logic [3:0] fin);
      logic [35:0] e;
      logic [31:0] r;
      logic [3:0] ix;
      int n;
      e = calc(a, b, ct, fin);
      ix = ct[16] ? ct[15:12] : ct[11:8];
      bus_wr(4'h0, a, 4'hf);
      bus_wr(4'h1, b, 4'hf);
      bus_wr(4'h2, ct, 4'hf);
      bus_wr(4'h5, {28'h0, fin}, 4'hf);
      bus_wr(4'h3, 32'h1, 4'hf);
      n = 0;
      while (wb_valid !== 1'b1 && branch_valid !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      chk("branch_pulse", {31'h0, ct[6]}, {31'h0, branch_valid});
      if (ct[6])
         chk("branch_target", {e[31:1], 1'b0}, branch_target);
      else
         chk("wb_index", {28'h0, ix}, {28'h0, wb_index});
      chk("wb_data", e[31:0], wb_data);
      @(negedge clk);
      chk("pulse_end", 32'h0, {31'h0, wb_valid | branch_valid});
      chk("flags_out", {28'h0, e[35:32]}, {28'h0, flags_out});
      bus_rd(4'h4, r);
      chk("result", e[31:0], r);
      if (ct[6])
         chk("model_pc", {e[31:1], 1'b0}, asd_regfile_model_inst.pc_q);
      else
         chk("model_reg", e[31:0], asd_regfile_model_inst.regs_q[ix]);
   endtask : run_op

   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      close_out();
   end

   initial
   begin
      sys_rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      miscompares = 0;
      checks_done = 0;
      seed_v = $urandom(32'hef69);
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      for (k = 4; k < 9; k++)
      begin
         bus_rd(4'(k), rd);
         chk("reset_reg", 32'h0, rd);
      end
      bus_wr(4'hc, 32'h1234, 4'hf);
      bus_rd(4'hc, rd);
      chk("unmapped", 32'h0, rd);
      bus_wr(4'h0, 32'hffffffff, 4'hf);
      bus_wr(4'h0, 32'h0, 4'h1);
      bus_rd(4'h0, rd);
      chk("byte_lane", 32'hffffff00, rd);
      $display("test bus done");
      for (k = 0; k < 8; k++)
         for (j = 0; j < 8; j++)
            run_op(ca[j % 4], cb[j % 4], mk(3'(k), 1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 4'h3, 1'b1, 12'h0),
               (j < 4) ? 4'h0 : 4'h2);
      $display("test corner done");
      bus_rd(4'h6, rd);
      chk("status_done", 32'h2, rd);
      bus_wr(4'h6, 32'h2, 4'hf);
      bus_rd(4'h6, rd);
      chk("status_clear", 32'h0, rd);
      for (k = 0; k < 4; k++)
      begin
         op = (k == 0) ? 3'h0 : (k == 1) ? 3'h2 : (k == 2) ? 3'h5 : 3'h6;
         run_op(32'h10, 32'h55, mk(op, 1'b1, 1'b1, 1'b0, 1'b0, 4'h2, 4'h4, 1'b1, 12'hfff), 4'h0);
         run_op(32'h10, 32'h55, mk(op, 1'b1, 1'b1, 1'b0, 1'b0, 4'h2, 4'h5, 1'b1, 12'h0), 4'h2);
      end
      $display("test immediate done");
      run_op(32'h80000000, 32'h80000000, mk(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h6, 4'h0, 1'b1, 12'h0), 4'ha);
      run_op(32'h5, 32'h1, mk(3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 4'h9, 4'h0, 1'b0, 12'h0), 4'h5);
      $display("test flags and dest done");
      // pc operand forms take no flag update; the first two use a constant operand, the pc-plus-register branch a register
      run_op(32'h1003, 32'h77, mk(3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 4'hf, 4'h2, 1'b1, 12'h123), 4'h0);
      run_op(32'h1003, 32'h77, mk(3'h2, 1'b0, 1'b1, 1'b1, 1'b0, 4'hf, 4'h2, 1'b1, 12'hfff), 4'h0);
      run_op(32'h2002, 32'h11, mk(3'h0, 1'b0, 1'b0, 1'b1, 1'b1, 4'hf, 4'hf, 1'b1, 12'h0), 4'h0);
      $display("test pc done");
      for (k = 0; k < 40; k++)
      begin
         op = 3'($urandom_range(7));
         // random operations never name the stack pointer or pc registers
         c = mk(op, 1'($urandom), (op == 3'h0 || op == 3'h2) ? 1'($urandom) : 1'b0, 1'b0, 1'b0,
            4'($urandom_range(12)), 4'($urandom_range(12)), 1'($urandom), 12'($urandom));
         run_op($urandom, $urandom, c, 4'($urandom));
      end
      $display("test random done");
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      bus_rd(4'h4, rd);
      chk("reset_result", 32'h0, rd);
      bus_rd(4'h6, rd);
      chk("reset_status", 32'h0, rd);
      bus_rd(4'h5, rd);
      chk("reset_flags", 32'h0, rd);
      $display("test reset done");
      close_out();
   end
endmodule : add_subtract_datapath_tb

//--- verif/asd_regfile_model.sv
/*
 * register-file side model: takes result writebacks and branch requests.
 * assumes one-cycle writeback and branch pulses from the datapath.
 */
`timescale 1ns/1ps
module asd_regfile_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_valid,
   input wire logic [3:0] wb_index,
   input wire logic [31:0] wb_data,
   input wire logic branch_valid,
   input wire logic [31:0] branch_target
);
   logic [31:0] regs_q [16];
   logic [31:0] pc_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pc_q <= 32'h0;
      end
      else
      begin
         if (wb_valid)
         begin
            regs_q[wb_index] <= wb_data;
         end
         if (branch_valid)
         begin
            pc_q <= branch_target;
         end
      end
   end
endmodule : asd_regfile_model
